/* arsb_code_format.sv */
// Turns a raw 12-bit converter code into a left-justified 16-bit result word.
// Assumes the converter delivers offset-binary codes on the same clock.
`timescale 1ns/10ps
`include "arsb_status_regs.svh"

module arsb_code_format (
	// Raw code and the coding to apply.
	input wire logic [`ARSB_CODE_BITS-1:0] raw_code,
	input wire arsb_pkg::arsb_coding_type coding,
	// Formatted word.
	output logic [`ARSB_WORD_BITS-1:0] result_word
);

	wire logic [`ARSB_CODE_BITS-1:0] flip_mask;
	wire logic [`ARSB_CODE_BITS-1:0] coded;

	// Two's complement is offset binary with the top bit inverted, so no adder is needed.
	assign flip_mask = (coding == arsb_pkg::ARSB_CODE_BIPOLAR) ? `ARSB_SIGN_FLIP : 12'h000;
	assign coded = raw_code ^ flip_mask;

	// The code sits in the top twelve bits; the low nibble is filled with zeros.
	assign result_word = {coded, `ARSB_RESULT_PAD};

endmodule : arsb_code_format

/* arsb_pkg.sv */
// Types shared by the result status bank modules.
// Assumes arsb_status_regs.svh supplies the widths used here.
`include "arsb_status_regs.svh"

package arsb_pkg;

	// One request on the reconfiguration port, valid while enable is high.
	typedef struct packed {
		logic enable;
		logic write;
		logic [`ARSB_ADDR_BITS-1:0] port_register_address;
		logic [`ARSB_WORD_BITS-1:0] write_data;
	} arsb_port_request_type;

	// One finished conversion from the converter, done is a one-cycle pulse.
	typedef struct packed {
		logic done;
		logic [4:0] channel;
		logic [`ARSB_CODE_BITS-1:0] code;
	} arsb_conversion_type;

	// Output coding applied to a raw offset-binary code.
	typedef enum logic [1:0] {
		ARSB_CODE_UNIPOLAR = 2'b01,
		ARSB_CODE_BIPOLAR = 2'b10
	} arsb_coding_type;

endpackage : arsb_pkg

/* arsb_port_master.sv */
// Behavioural model of the fabric logic that reaches the bank over the reconfiguration port.
// Assumes one caller at a time and that the bank shares clk with this model.
`timescale 1ns/10ps
`include "arsb_status_regs.svh"

module arsb_port_master (
	// Clock.
	input wire logic clk,
	// Request towards the bank.
	output arsb_pkg::arsb_port_request_type port_request,
	// Answer from the bank.
	input wire logic [`ARSB_WORD_BITS-1:0] port_read_data,
	input wire logic port_ready
);
	// The strobe rests low from time zero.
	initial begin
		port_request = '0;
	end

	// One request; writes only go to the configuration word or to scenarios testing refusal.
	// Released qualifiers show inverted values so nothing can lean on stale ones.
	// The answer on a read is handed back raw; the caller decides what it relies on.
	task automatic transfer(input logic wr, input logic [`ARSB_ADDR_BITS-1:0] addr,
		input logic [`ARSB_WORD_BITS-1:0] data, output logic [`ARSB_WORD_BITS-1:0] rdata,
		output logic ok);
		int i;
		ok = 1'b0;
		rdata = '0;
		@(posedge clk);
		#1;
		port_request = {1'b1, wr, addr, data};
		@(posedge clk);
		#1;
		port_request = {1'b0, ~wr, ~addr, ~data};
		for (i = 0; i < 4 && !ok; i++) begin
			if (port_ready === 1'b1) begin
				ok = 1'b1;
				rdata = port_read_data;
			end else begin
				@(posedge clk);
				#1;
			end
		end
	endtask : transfer
endmodule : arsb_port_master

/* arsb_result_slot.sv */
// One read-only result register that loads only on a conversion of its own channel.
// Assumes a synchronous active-high reset and single-cycle done pulses.
`timescale 1ns/10ps
`include "arsb_status_regs.svh"

module arsb_result_slot #(
	parameter logic [4:0] CHANNEL = 5'h00
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Finished conversion and its formatted word.
	input wire arsb_pkg::arsb_conversion_type conversion,
	input wire logic [`ARSB_WORD_BITS-1:0] formatted_word,
	// Stored result.
	output logic [`ARSB_WORD_BITS-1:0] value
);

	wire logic own_channel;

	assign own_channel = conversion.done && (conversion.channel == CHANNEL);

	// The value holds between conversions, so repeated reads see the same word.
	always_ff @(posedge clk) begin
		if (reset) begin
			value <= `ARSB_RESULT_RESET;
		end else if (own_channel) begin
			value <= formatted_word;
		end
	end

endmodule : arsb_result_slot

/* arsb_status_bank.sv */
// Read-only result status bank of the dual converter and monitor unit.
// Assumes the converter and the port master share clk; nothing here crosses a clock domain.
//
// Operation
// - Die temperature result sits at 00h in the upper twelve bits.
// - Core, auxiliary and memory supply results sit at 01h, 02h, 06h.
// - Dedicated differential input result at 03h uses the configured coding.
// - Positive reference converted on the supply path, stored at 04h.
// - Negative reference always stored two's complement (bipolar) at 05h.
// - Negative reference uses supply scaling, one code step is 3V/4096.
// - Address 07h is unused; readers must not rely on its value.
// - First converter calibration words sit at 08h, 09h and 0Ah.
// - Every result is sixteen bits, code in the top twelve, low four empty.
// - Port writes never change the results; the master should only read them.
// - A channel's result goes to the address equal to its channel number.
// - Software writing configuration word 0 picks unipolar or bipolar coding.
`timescale 1ns/10ps
`include "arsb_status_regs.svh"

module arsb_status_bank (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Reconfiguration port request.
	input wire arsb_pkg::arsb_port_request_type port_request,
	// Finished conversions from the converter.
	input wire arsb_pkg::arsb_conversion_type conversion,
	// Reconfiguration port answer.
	output logic [`ARSB_WORD_BITS-1:0] port_read_data,
	output logic port_ready
);

	// Stored words, one per slot; slot 07h is never built.
	wire logic [`ARSB_SLOT_COUNT-1:0][`ARSB_WORD_BITS-1:0] slot_value;

	// Configuration word 0 as written by software.
	logic [`ARSB_WORD_BITS-1:0] config0;
	logic [`ARSB_WORD_BITS-1:0] next_read_data;

	// Decoded port request.
	wire logic read_strobe;
	wire logic write_strobe;
	wire logic addr_is_slot;
	wire logic addr_is_unused;
	wire logic addr_is_config0;
	wire logic [3:0] slot_index;
	wire logic config0_write;

	// Coding and formatting of the incoming conversion.
	wire logic bipolar_mode;
	wire arsb_pkg::arsb_coding_type channel_coding;
	wire logic [`ARSB_WORD_BITS-1:0] formatted_word;

	// Address decode: a request counts only while enable is high.
	assign read_strobe = port_request.enable && !port_request.write;
	assign write_strobe = port_request.enable && port_request.write;
	assign addr_is_slot = port_request.port_register_address <= `ARSB_ADDR_LAST_SLOT;
	assign addr_is_unused = port_request.port_register_address == `ARSB_ADDR_UNUSED;
	assign addr_is_config0 = port_request.port_register_address == `ARSB_ADDR_CONFIG0;
	assign slot_index = port_request.port_register_address[3:0];

	// Only configuration word 0 accepts writes; status addresses ignore them.
	assign config0_write = write_strobe && addr_is_config0;

	assign bipolar_mode = config0[`ARSB_CONFIG0_BIPOLAR_BIT];

	// Coding per channel: the dedicated input follows software, the negative
	// reference is always bipolar so offsets just below zero stay visible, and
	// every supply-path channel stays unipolar with 3V/4096 per step.
	assign channel_coding =
		(conversion.channel == 5'(`ARSB_ADDR_NEG_REF)) ? arsb_pkg::ARSB_CODE_BIPOLAR :
		((conversion.channel == 5'(`ARSB_ADDR_DEDICATED)) && bipolar_mode) ?
		arsb_pkg::ARSB_CODE_BIPOLAR :
		arsb_pkg::ARSB_CODE_UNIPOLAR;

	// One shared formatter serves all slots, since only one conversion ends per cycle.
	arsb_code_format u_format (
		.raw_code(conversion.code),
		.coding(channel_coding),
		.result_word(formatted_word)
	);

	// One register per channel except 07h, each loading only on its own channel number.
	for (genvar i = 0; i < `ARSB_SLOT_COUNT; i++) begin : g_slot
		if (i == 7) begin : g_unused
			// The unused slot holds no storage and reads as a fixed word.
			assign slot_value[i] = `ARSB_UNMAPPED_DATA;
		end else begin : g_result
			arsb_result_slot #(
				.CHANNEL(5'(i))
			) u_slot (
				.clk(clk),
				.reset(reset),
				.conversion(conversion),
				.formatted_word(formatted_word),
				.value(slot_value[i])
			);
		end
	end

	// Read selection; addresses outside the bank answer with a zero word.
	assign next_read_data =
		addr_is_config0 ? config0 :
		addr_is_unused ? `ARSB_UNMAPPED_DATA :
		addr_is_slot ? slot_value[slot_index] :
		`ARSB_UNMAPPED_DATA;

	// Software owns the coding select; it affects conversions that finish afterwards.
	always_ff @(posedge clk) begin
		if (reset) begin
			config0 <= `ARSB_CONFIG0_RESET;
		end else if (config0_write) begin
			config0 <= port_request.write_data;
		end
	end

	// Every accepted request, read or write, is answered one cycle later.
	always_ff @(posedge clk) begin
		if (reset) begin
			port_ready <= 1'b0;
			port_read_data <= `ARSB_UNMAPPED_DATA;
		end else begin
			port_ready <= port_request.enable;
			if (read_strobe) begin
				port_read_data <= next_read_data;
			end
		end
	end

	// Checks on the bank's own behaviour.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	wire logic any_low_nibble;
	assign any_low_nibble = |{slot_value[0][3:0], slot_value[1][3:0], slot_value[2][3:0],
		slot_value[3][3:0], slot_value[4][3:0], slot_value[5][3:0], slot_value[6][3:0],
		slot_value[8][3:0], slot_value[9][3:0], slot_value[10][3:0]};

	sequence s_convert(logic [4:0] ch);
		conversion.done && (conversion.channel == ch);
	endsequence

	sequence s_read_at(logic [6:0] addr);
		read_strobe && (port_request.port_register_address == addr);
	endsequence

	sequence s_quiet;
		!conversion.done;
	endsequence

	property p_temperature;
		s_convert(5'h00) |=> slot_value[0] == {$past(conversion.code), 4'h0};
	endproperty
	a_temperature: assert property (p_temperature)
		else $error("Temperature result not stored at its slot.");

	property p_supplies;
		conversion.done && (conversion.channel inside {5'h01, 5'h02, 5'h06})
		|=> slot_value[$past(conversion.channel[3:0])] == {$past(conversion.code), 4'h0};
	endproperty
	a_supplies: assert property (p_supplies)
		else $error("Supply result not stored unipolar at its slot.");

	property p_dedicated;
		s_convert(5'h03)
		|=> slot_value[3][15:4] == ($past(conversion.code) ^ {$past(bipolar_mode), 11'h000});
	endproperty
	a_dedicated: assert property (p_dedicated)
		else $error("Dedicated input coding does not follow the mode.");

	property p_positive_reference;
		s_convert(5'h04) |=> slot_value[4] == {$past(conversion.code), 4'h0};
	endproperty
	a_positive_reference: assert property (p_positive_reference)
		else $error("Positive reference result wrong.");

	property p_negative_reference;
		s_convert(5'h05) |=> slot_value[5][15:4] == ($past(conversion.code) ^ 12'h800);
	endproperty
	a_negative_reference: assert property (p_negative_reference)
		else $error("Negative reference not coded bipolar.");

	property p_unused_read;
		s_read_at(7'h07) |=> port_ready && (port_read_data == 16'h0000);
	endproperty
	a_unused_read: assert property (p_unused_read)
		else $error("Unused slot answered wrongly.");

	property p_calibration;
		conversion.done && (conversion.channel inside {5'h08, 5'h09, 5'h0a})
		|=> slot_value[$past(conversion.channel[3:0])] == {$past(conversion.code), 4'h0};
	endproperty
	a_calibration: assert property (p_calibration)
		else $error("Calibration word not stored at its slot.");

	property p_low_nibble;
		!any_low_nibble;
	endproperty
	a_low_nibble: assert property (p_low_nibble)
		else $error("Low four bits of a result are not zero.");

	property p_write_ignored;
		write_strobe && (port_request.port_register_address < 7'h40) ##0 s_quiet
		|=> $stable(slot_value) && port_ready && $stable(config0);
	endproperty
	a_write_ignored: assert property (p_write_ignored)
		else $error("A write changed a status register.");

	property p_read_back;
		read_strobe && addr_is_slot ##0 s_quiet
		|=> port_ready && (port_read_data == slot_value[$past(slot_index)]);
	endproperty
	a_read_back: assert property (p_read_back)
		else $error("Read did not return the slot at that address.");

	property p_mode_write;
		config0_write
		|=> bipolar_mode == $past(port_request.write_data[`ARSB_CONFIG0_BIPOLAR_BIT]);
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("Coding select not taken from configuration write.");

	property p_hold;
		s_quiet |=> $stable(slot_value);
	endproperty
	a_hold: assert property (p_hold)
		else $error("A result changed without a conversion.");

	property p_ready_timing;
		port_request.enable |=> port_ready ##1 (port_ready == $past(port_request.enable));
	endproperty
	a_ready_timing: assert property (p_ready_timing)
		else $error("Port answer not one cycle after the request.");

	// Port answer checks beyond the rules: idle cycles, held read data, unmapped reads.
	sequence s_unmapped_read;
		read_strobe && !addr_is_slot && !addr_is_config0;
	endsequence

	sequence s_dropped;
		conversion.done && ((conversion.channel == 5'h07) || (conversion.channel > 5'h0a));
	endsequence

	property p_idle_no_ready;
		!port_request.enable |=> !port_ready;
	endproperty
	a_idle_no_ready: assert property (p_idle_no_ready)
		else $error("Ready raised without a request.");

	property p_read_data_hold;
		!read_strobe |=> $stable(port_read_data);
	endproperty
	a_read_data_hold: assert property (p_read_data_hold)
		else $error("Read data moved without a read.");

	property p_unmapped_read;
		s_unmapped_read |=> port_ready && (port_read_data == 16'h0000);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("Unmapped address did not read as zero.");

	property p_config_read;
		read_strobe && addr_is_config0 |=> port_read_data == $past(config0);
	endproperty
	a_config_read: assert property (p_config_read)
		else $error("Configuration word 0 read back wrongly.");

	// Software is the only writer of the coding select.
	property p_config_hold;
		!config0_write |=> $stable(config0);
	endproperty
	a_config_hold: assert property (p_config_hold)
		else $error("Configuration word 0 changed without a write to it.");

	property p_write_keeps_data;
		write_strobe |=> $stable(port_read_data);
	endproperty
	a_write_keeps_data: assert property (p_write_keeps_data)
		else $error("A write disturbed the read data.");

	// Conversions that name no slot must leave the whole bank alone.
	property p_dropped_channel;
		s_dropped |=> $stable(slot_value);
	endproperty
	a_dropped_channel: assert property (p_dropped_channel)
		else $error("A conversion on an unmapped channel changed a result.");

	// The dedicated input in each coding, chosen at the moment it completes.
	property p_dedicated_unipolar;
		s_convert(5'h03) ##0 !bipolar_mode |=> slot_value[3] == {$past(conversion.code), 4'h0};
	endproperty
	a_dedicated_unipolar: assert property (p_dedicated_unipolar)
		else $error("Dedicated input not stored as offset binary in unipolar mode.");

	property p_dedicated_bipolar;
		s_convert(5'h03) ##0 bipolar_mode |=> slot_value[3][15] == !$past(conversion.code[11]);
	endproperty
	a_dedicated_bipolar: assert property (p_dedicated_bipolar)
		else $error("Dedicated input sign bit not flipped in bipolar mode.");

	property p_neighbour_hold;
		conversion.done && (conversion.channel != 5'h03) |=> $stable(slot_value[3]);
	endproperty
	a_neighbour_hold: assert property (p_neighbour_hold)
		else $error("Dedicated input result changed on another channel.");

endmodule : arsb_status_bank

/* arsb_status_bank_tb_top.sv */
// Self-checking bench for the result status bank.
// Assumes the port master model drives the port and this module drives conversions.
`timescale 1ns/10ps
`include "arsb_status_regs.svh"

module arsb_status_bank_tb_top;
	logic clk;
	logic reset;
	arsb_pkg::arsb_conversion_type conversion;
	arsb_pkg::arsb_port_request_type port_request;
	logic [`ARSB_WORD_BITS-1:0] port_read_data;
	logic port_ready;
	int failures;
	int checked;

	arsb_status_bank arsb_status_bank_inst (.clk(clk), .reset(reset),
		.port_request(port_request), .conversion(conversion),
		.port_read_data(port_read_data), .port_ready(port_ready));
	arsb_port_master arsb_port_master_inst (.clk(clk), .port_request(port_request),
		.port_read_data(port_read_data), .port_ready(port_ready));

	// The 25 MHz clock.
	always #20 clk = ~clk;

	// Single exit of the run.
	task automatic test_done();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	task automatic check_word(input logic [15:0] actual, input logic [15:0] expected);
		checked++;
		if (actual !== expected) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, actual, expected);
		end
	endtask : check_word

	// A request left without a ready is a failure and ends the run, since later reads mean nothing.
	task automatic access(input logic wr, input logic [6:0] addr, input logic [15:0] data,
		output logic [15:0] rdata);
		logic ok;
		arsb_port_master_inst.transfer(wr, addr, data, rdata, ok);
		if (ok !== 1'b1) begin
			failures++;
			test_done();
		end
	endtask : access

	task automatic expect_reg(input logic [6:0] addr, input logic [15:0] expected);
		logic [15:0] rdata;
		access(1'b0, addr, 16'h0000, rdata);
		check_word(rdata, expected);
	endtask : expect_reg

	task automatic write_reg(input logic [6:0] addr, input logic [15:0] data);
		logic [15:0] rdata;
		access(1'b1, addr, data, rdata);
	endtask : write_reg

	task automatic convert(input logic [4:0] channel, input logic [11:0] code);
		@(posedge clk);
		#1;
		conversion = {1'b1, channel, code};
		@(posedge clk);
		#1;
		conversion = {1'b0, ~channel, ~code};
	endtask : convert

	// Distinct codes per channel, with the top bit set on some so a sign flip shows.
	function automatic logic [11:0] code_of(input logic [4:0] ch);
		return 12'h8c1 + 12'h111 * {7'h00, ch};
	endfunction : code_of

	function automatic logic [15:0] word_of(input logic [11:0] code, input logic bipolar);
		return {bipolar ? code ^ `ARSB_SIGN_FLIP : code, 4'h0};
	endfunction : word_of

	task automatic test_reset_values();
		for (int a = 0; a <= 10; a++) begin
			if (a != 7) expect_reg(a[6:0], 16'h0000);
		end
		expect_reg(7'h40, 16'h0000);
	endtask : test_reset_values

	// Every fixed-coding channel lands at its own address, left-justified.
	task automatic test_fixed_channels();
		logic [4:0] ch;
		for (int a = 0; a <= 10; a++) begin
			ch = a[4:0];
			if (a != 3 && a != 7) begin
				convert(ch, code_of(ch));
				expect_reg(a[6:0], word_of(code_of(ch), a == 5));
			end
		end
	endtask : test_fixed_channels

	task automatic test_dedicated_coding();
		convert(5'h03, 12'h812);
		expect_reg(7'h03, word_of(12'h812, 1'b0));
		write_reg(7'h40, 16'h0400);
		expect_reg(7'h40, 16'h0400);
		convert(5'h03, 12'h812);
		expect_reg(7'h03, word_of(12'h812, 1'b1));
		convert(5'h05, 12'h123);
		expect_reg(7'h05, word_of(12'h123, 1'b1));
		write_reg(7'h40, 16'h0000);
		convert(5'h03, 12'h7f0);
		expect_reg(7'h03, word_of(12'h7f0, 1'b0));
	endtask : test_dedicated_coding

	// Writes into the status space are answered but leave the words alone.
	task automatic test_writes_ignored();
		write_reg(7'h01, 16'hffff);
		write_reg(7'h0a, 16'h5a5a);
		expect_reg(7'h01, word_of(code_of(5'h01), 1'b0));
		expect_reg(7'h0a, word_of(code_of(5'h0a), 1'b0));
	endtask : test_writes_ignored

	// Conversions on unused channels and on neighbours leave a result untouched.
	task automatic test_hold();
		logic [15:0] rdata;
		logic [15:0] expected;
		convert(5'h07, 12'hfff);
		convert(5'h0b, 12'hfff);
		convert(5'h01, 12'h3c7);
		expect_reg(7'h01, word_of(12'h3c7, 1'b0));
		for (int a = 0; a <= 10; a++) begin
			if (a != 1 && a != 3 && a != 7) begin
				// Slot 05h last took the bipolar code of the dedicated coding scenario.
				expected = word_of(code_of(a[4:0]), 1'b0);
				if (a == 5) expected = word_of(12'h123, 1'b1);
				expect_reg(a[6:0], expected);
			end
		end
		// The unused and unmapped words are read for the answer only; their value is not relied on.
		access(1'b0, 7'h07, 16'h0000, rdata);
		access(1'b0, 7'h0b, 16'h0000, rdata);
	endtask : test_hold

	// Reset, then the scenarios in order.
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		conversion = '0;
		failures = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		#1;
		reset = 1'b0;
		test_reset_values();
		test_fixed_channels();
		test_dedicated_coding();
		test_writes_ignored();
		test_hold();
		test_done();
	end
endmodule : arsb_status_bank_tb_top

/* arsb_status_regs.svh */
// Offsets, field positions, reset values and timing counts of the result status bank.
// Included by its bare name from the package user files; holds definitions only.
`ifndef ARSB_STATUS_REGS_SVH
`define ARSB_STATUS_REGS_SVH

// Port and word geometry.
`define ARSB_ADDR_BITS 7
`define ARSB_WORD_BITS 16
`define ARSB_CODE_BITS 12
`define ARSB_SLOT_COUNT 11

// Status register offsets, each equal to the converter channel number; control offsets start at 40h.
`define ARSB_ADDR_TEMPERATURE 7'h00
`define ARSB_ADDR_CORE_SUPPLY 7'h01
`define ARSB_ADDR_AUX_SUPPLY 7'h02
`define ARSB_ADDR_DEDICATED 7'h03
`define ARSB_ADDR_POS_REF 7'h04
`define ARSB_ADDR_NEG_REF 7'h05
`define ARSB_ADDR_MEMORY_SUPPLY 7'h06
`define ARSB_ADDR_UNUSED 7'h07
`define ARSB_ADDR_SUPPLY_OFFSET_CAL 7'h08
`define ARSB_ADDR_CONV_OFFSET_CAL 7'h09
`define ARSB_ADDR_CONV_GAIN_CAL 7'h0a
`define ARSB_ADDR_LAST_SLOT 7'h0a
`define ARSB_ADDR_FIRST_CONTROL 7'h40
`define ARSB_ADDR_CONFIG0 7'h40

// Configuration word 0: position of the bipolar coding select bit.
`define ARSB_CONFIG0_BIPOLAR_BIT 10

// Reset values and fill values.
`define ARSB_RESULT_RESET 16'h0000
`define ARSB_CONFIG0_RESET 16'h0000
`define ARSB_UNMAPPED_DATA 16'h0000
`define ARSB_RESULT_PAD 4'h0
`define ARSB_SIGN_FLIP 12'h800

// Cycles from an accepted port request to its ready pulse.
`define ARSB_PORT_LATENCY 1

`endif
